// >>> rtl/pmc_core.sv
// Purpose: power mode sequencer with AHB-Lite register slave
// Assumes: CPU pulses halt/wait instructions; irq inputs are synchronous
// Notes: auto-wakeup RC is modelled as an enable of the system clock
//
// Summary of operation
// - reset enters stabilisation, then run mode, normal master clock
// - slow bit divides CPU and peripheral clock by 32
// - wait during slow keeps divided peripheral clock
// - wait stops the CPU clock and the measure RC
// - entering wait clears the interrupt mask
// - wait ends only on interrupt or reset
// - CPU stacks condition code, masks during service
// - plain halt when no active halt, autowake clear
// - halt exit restarts oscillator, waits 256/4096
// - entering halt forces interrupt mask to zero
// - halt stops oscillator and all peripheral clocks
// - watchdog halt option decides watchdog reset
// - timer enables select active halt mode
// - active halt reset exit waits 256, as reset clears the long delay bit
// - active halt interrupt exit resumes at once
// - entering active halt clears interrupt mask
// - active halt runs oscillator and timer only
// - active halt never gives watchdog reset
// - autowake halt runs RC, divider, prescaler
// - expiry sets flag, irq, then stabilises
// - reading autowake status clears flag and irq
// - measure bit routes RC to timer capture
// - PLL enabled adds start-up delay after stabilisation
// - autowake time is 64 times prescale, 00h forbidden
// - writes never change the autowake flag
`timescale 1ns/10ps
module pmc_core #(
  parameter int STAB_LONG = pmc_pkg::PMC_STAB_LONG
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic wait_instr,
  input wire logic halt_instr,
  input wire logic irq_any,
  input wire logic irq_halt_wake,
  input wire logic irq_active_wake,
  input wire logic watchdog_active,
  output logic clear_imask,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_on,
  output logic timer_clk_en,
  output logic awrc_on,
  output logic aw_capture_sel,
  output logic autowake_irq,
  output logic watchdog_reset,
  output logic [2:0] mode
);
  localparam int STAB_SHORT = pmc_pkg::PMC_STAB_SHORT;

  pmc_pkg::pmc_mode_t mode_reg;
  logic [7:0] prescale_reg;
  logic [1:0] awcs_reg;
  logic aw_flag_reg;
  logic [3:0] clkctrl_reg;
  logic [3:0] timcfg_reg;
  logic [pmc_pkg::PMC_CNT_W-1:0] cnt_reg;
  logic [7:0] aw_cnt_reg;
  logic [3:0] rc_start_reg;
  logic pll_done_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic slow_tick;
  logic aw_tick;
  logic active_halt_en;
  logic aw_expire;
  logic rd_awcs;
  logic [31:0] rdata_next;
  pmc_pkg::pmc_gate_t gate_next;

  // Slow clock enable: oscillator rate over 32
  pmc_divider #(.DIV(pmc_pkg::PMC_SLOW_DIV)) u_slow_div (
    .clk(hclk),
    .rst_n(hresetn),
    .ena(1'b1),
    .clr(1'b0),
    .tick(slow_tick)
  );

  // Autowake fixed divider, runs only with the RC oscillator
  pmc_divider #(.DIV(pmc_pkg::PMC_AW_FIXED_DIV)) u_aw_div (
    .clk(hclk),
    .rst_n(hresetn),
    .ena(mode_reg == pmc_pkg::PMC_AW_HALT && rc_start_reg == '0),
    .clr(mode_reg != pmc_pkg::PMC_AW_HALT),
    .tick(aw_tick)
  );

  // Active halt decode from timer interrupt settings
  assign active_halt_en = timcfg_reg[pmc_pkg::PMC_TC_TIMEBASE1_IRQ_ENABLE_BIT]
    | (timcfg_reg[pmc_pkg::PMC_TC_OVERFLOW_IRQ_ENABLE_BIT] & ~timcfg_reg[pmc_pkg::PMC_TC_CKHI_BIT]
       & timcfg_reg[pmc_pkg::PMC_TC_CKLO_BIT]);
  assign aw_expire = aw_tick && (aw_cnt_reg == 8'h01);
  assign rd_awcs = rd_pend_reg && (addr_reg == pmc_pkg::PMC_OFS_AWCS);

  // AHB address phase capture; slave is zero wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      rd_pend_reg <= hsel && htrans[1] && !hwrite;
      addr_reg <= haddr[7:0];
    end
  end

  // Software-written control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prescale_reg <= pmc_pkg::PMC_PRESCALE_RST;
      awcs_reg[1:0] <= 2'b00;
      clkctrl_reg <= 4'h0;
      timcfg_reg <= 4'h0;
    end
    else if (wr_pend_reg)
    begin
      case (addr_reg)
        pmc_pkg::PMC_OFS_PRESCALE:
          if (hwdata[7:0] != 8'h00)
            prescale_reg <= hwdata[7:0];
        pmc_pkg::PMC_OFS_AWCS:
          awcs_reg[1:0] <= hwdata[1:0];
        pmc_pkg::PMC_OFS_CLKCTRL:
          clkctrl_reg <= hwdata[3:0];
        pmc_pkg::PMC_OFS_TIMCFG:
          timcfg_reg <= hwdata[3:0];
        default:
          prescale_reg <= prescale_reg;
      endcase
    end
  end

  // Autowake flag: set by expiry only, cleared by read, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      aw_flag_reg <= 1'b0;
    else if (aw_expire)
      aw_flag_reg <= 1'b1;
    else if (rd_awcs)
      aw_flag_reg <= 1'b0;
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (addr_reg)
      pmc_pkg::PMC_OFS_PRESCALE: rdata_next[7:0] = prescale_reg;
      pmc_pkg::PMC_OFS_AWCS: rdata_next[2:0] = {aw_flag_reg, awcs_reg};
      pmc_pkg::PMC_OFS_CLKCTRL: rdata_next[3:0] = clkctrl_reg;
      pmc_pkg::PMC_OFS_TIMCFG: rdata_next[3:0] = timcfg_reg;
      pmc_pkg::PMC_OFS_STATUS: rdata_next[2:0] = mode_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end
  assign hrdata = rdata_next;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Mode sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_reg <= pmc_pkg::PMC_STAB;
      cnt_reg <= '0;
      pll_done_reg <= 1'b0;
    end
    else
    begin
      case (mode_reg)
        pmc_pkg::PMC_RUN:
          if (halt_instr)
          begin
            // Kind of halt frozen at the instruction
            if (active_halt_en)
              mode_reg <= pmc_pkg::PMC_ACTIVE_HALT;
            else if (awcs_reg[pmc_pkg::PMC_AW_EN_BIT])
              mode_reg <= pmc_pkg::PMC_AW_HALT;
            else
              mode_reg <= pmc_pkg::PMC_HALT;
          end
          else if (wait_instr)
            mode_reg <= pmc_pkg::PMC_WAIT;
        pmc_pkg::PMC_WAIT:
          if (irq_any)
            mode_reg <= pmc_pkg::PMC_RUN;
        pmc_pkg::PMC_HALT, pmc_pkg::PMC_AW_HALT:
          if (irq_halt_wake || aw_expire)
          begin
            mode_reg <= pmc_pkg::PMC_STAB;
            cnt_reg <= '0;
            pll_done_reg <= 1'b0;
          end
        pmc_pkg::PMC_ACTIVE_HALT:
          if (irq_active_wake)
            mode_reg <= pmc_pkg::PMC_RUN;
        pmc_pkg::PMC_STAB:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if ({19'd0, cnt_reg} == (clkctrl_reg[pmc_pkg::PMC_CK_LONGDLY_BIT]
              ? STAB_LONG - 1 : STAB_SHORT - 1))
          begin
            cnt_reg <= '0;
            mode_reg <= clkctrl_reg[pmc_pkg::PMC_CK_PLL_BIT]
              ? pmc_pkg::PMC_PLL_WAIT : pmc_pkg::PMC_RUN;
          end
        end
        pmc_pkg::PMC_PLL_WAIT:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == pmc_pkg::PMC_CNT_W'(pmc_pkg::PMC_PLL_START_CYC - 1))
          begin
            cnt_reg <= '0;
            pll_done_reg <= 1'b1;
            mode_reg <= pmc_pkg::PMC_RUN;
          end
        end
        default:
          mode_reg <= pmc_pkg::PMC_RUN;
      endcase
    end
  end

  // Autowake prescaler and RC start time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aw_cnt_reg <= 8'h00;
      rc_start_reg <= 4'h0;
    end
    else if (mode_reg != pmc_pkg::PMC_AW_HALT)
    begin
      aw_cnt_reg <= prescale_reg;
      rc_start_reg <= 4'(pmc_pkg::PMC_RC_START_CYC);
    end
    else if (rc_start_reg != 4'h0)
      rc_start_reg <= rc_start_reg - 1'b1;
    else if (aw_tick && aw_cnt_reg != 8'h01)
      aw_cnt_reg <= aw_cnt_reg - 1'b1;
  end

  // Clock gating per mode
  always_comb
  begin
    gate_next = '0;
    case (mode_reg)
      pmc_pkg::PMC_RUN:
      begin
        gate_next.cpu_en = clkctrl_reg[pmc_pkg::PMC_CK_SLOW_BIT] ? slow_tick : 1'b1;
        gate_next.periph_en = gate_next.cpu_en;
        gate_next.osc_on = 1'b1;
        gate_next.timer_en = gate_next.cpu_en;
        gate_next.awrc_on = awcs_reg[pmc_pkg::PMC_AW_MEAS_BIT];
      end
      pmc_pkg::PMC_WAIT:
      begin
        gate_next.periph_en = clkctrl_reg[pmc_pkg::PMC_CK_SLOW_BIT]
          ? slow_tick : 1'b1;
        gate_next.osc_on = 1'b1;
        gate_next.timer_en = gate_next.periph_en;
      end
      pmc_pkg::PMC_ACTIVE_HALT:
      begin
        gate_next.osc_on = 1'b1;
        gate_next.timer_en = 1'b1;
      end
      pmc_pkg::PMC_AW_HALT:
        gate_next.awrc_on = 1'b1;
      pmc_pkg::PMC_STAB, pmc_pkg::PMC_PLL_WAIT:
        gate_next.osc_on = 1'b1;
      default:
        gate_next = '0;
    endcase
  end

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      osc_on <= 1'b1;
      timer_clk_en <= 1'b0;
      awrc_on <= 1'b0;
      aw_capture_sel <= 1'b0;
      autowake_irq <= 1'b0;
      watchdog_reset <= 1'b0;
      clear_imask <= 1'b0;
      mode <= 3'h0;
    end
    else
    begin
      cpu_clk_en <= gate_next.cpu_en;
      periph_clk_en <= gate_next.periph_en;
      osc_on <= gate_next.osc_on;
      timer_clk_en <= gate_next.timer_en;
      awrc_on <= gate_next.awrc_on;
      aw_capture_sel <= (mode_reg == pmc_pkg::PMC_RUN)
        && awcs_reg[pmc_pkg::PMC_AW_MEAS_BIT];
      autowake_irq <= aw_expire || (autowake_irq && !rd_awcs);
      watchdog_reset <= (mode_reg == pmc_pkg::PMC_RUN) && halt_instr && watchdog_active
        && !active_halt_en && clkctrl_reg[pmc_pkg::PMC_CK_WDHALT_BIT];
      clear_imask <= (mode_reg == pmc_pkg::PMC_RUN)
        && (halt_instr || wait_instr);
      mode <= mode_reg;
    end
  end

  // is kept by the CPU core: it stacks the condition code itself

  a_wait_cpu_off: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == pmc_pkg::PMC_WAIT |=> !cpu_clk_en)
    else $error("cpu clock ran in wait");
  a_halt_all_off: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == pmc_pkg::PMC_HALT |=> !osc_on && !periph_clk_en)
    else $error("clock ran in halt");
  a_active_timer: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == pmc_pkg::PMC_ACTIVE_HALT |=> osc_on && timer_clk_en && !periph_clk_en)
    else $error("active halt gating wrong");
  a_active_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == pmc_pkg::PMC_ACTIVE_HALT && irq_active_wake |=> mode_reg == pmc_pkg::PMC_RUN)
    else $error("active halt exit delayed");
  a_halt_wake_stab: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == pmc_pkg::PMC_HALT && irq_halt_wake
      |=> mode_reg == pmc_pkg::PMC_STAB [*8])
    else $error("halt exit skipped stabilisation");
  a_flag_read_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_awcs && !aw_expire |=> !aw_flag_reg && !autowake_irq)
    else $error("flag not cleared by read");
  a_flag_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
    !aw_expire && !rd_awcs |=> $stable(aw_flag_reg))
    else $error("flag changed without cause");
  a_halt_choice: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == pmc_pkg::PMC_RUN && halt_instr && active_halt_en
      |=> mode_reg == pmc_pkg::PMC_ACTIVE_HALT)
    else $error("active halt not chosen");
  a_mask_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == pmc_pkg::PMC_RUN && halt_instr |=> clear_imask)
    else $error("mask not cleared on halt");
  // Clearing slow inside the gap may restore full rate at once
  a_slow_rate: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_clk_en && mode_reg == pmc_pkg::PMC_RUN && clkctrl_reg[pmc_pkg::PMC_CK_SLOW_BIT]
      && $past(mode_reg) == mode_reg
      |=> (!cpu_clk_en || !clkctrl_reg[pmc_pkg::PMC_CK_SLOW_BIT]) [*8])
    else $error("slow clock too fast");
endmodule // pmc_core

// >>> rtl/pmc_pkg.sv
// Purpose: shared constants and types for the power mode controller
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: offsets are byte addresses
package pmc_pkg;
  // Register byte offsets
  localparam logic [7:0] PMC_OFS_PRESCALE = 8'h00;
  localparam logic [7:0] PMC_OFS_AWCS = 8'h04;
  localparam logic [7:0] PMC_OFS_CLKCTRL = 8'h08;
  localparam logic [7:0] PMC_OFS_TIMCFG = 8'h0c;
  localparam logic [7:0] PMC_OFS_STATUS = 8'h10;
  // Autowake control/status fields
  localparam int PMC_AW_EN_BIT = 0;
  localparam int PMC_AW_MEAS_BIT = 1;
  localparam int PMC_AW_FLAG_BIT = 2;
  // Clock control fields
  localparam int PMC_CK_SLOW_BIT = 0;
  localparam int PMC_CK_LONGDLY_BIT = 1;
  localparam int PMC_CK_PLL_BIT = 2;
  localparam int PMC_CK_WDHALT_BIT = 3;
  // Timer configuration fields
  localparam int PMC_TC_TIMEBASE1_IRQ_ENABLE_BIT = 0;
  localparam int PMC_TC_OVERFLOW_IRQ_ENABLE_BIT = 1;
  localparam int PMC_TC_CKLO_BIT = 2;
  localparam int PMC_TC_CKHI_BIT = 3;
  // Reset values
  localparam logic [7:0] PMC_PRESCALE_RST = 8'hff;
  // Timing
  localparam int PMC_SLOW_DIV = 32;
  localparam int PMC_AW_FIXED_DIV = 64;
  localparam int PMC_STAB_SHORT = 256;
  localparam int PMC_STAB_LONG = 4096;
  localparam int PMC_PLL_START_CYC = 16;
  localparam int PMC_RC_START_CYC = 4;
  localparam int PMC_CNT_W = 13;
  // Operating modes
  typedef enum logic [2:0] {
    PMC_RUN, PMC_WAIT, PMC_HALT, PMC_ACTIVE_HALT, PMC_AW_HALT, PMC_STAB, PMC_PLL_WAIT
  } pmc_mode_t;
  // Clock gate bundle
  typedef struct packed {
    logic cpu_en;
    logic periph_en;
    logic osc_on;
    logic timer_en;
    logic awrc_on;
  } pmc_gate_t;
endpackage

// >>> rtl/pmc_divider.sv
// Purpose: free counter producing a one-cycle enable pulse
// Assumes: ena gates counting; clr restarts the count
// Notes: period is the DIV parameter times the enabling rate
`timescale 1ns/10ps
module pmc_divider #(
  parameter int DIV = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ena,
  input wire logic clr,
  output logic tick
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt_reg;

  // Wraps at DIV and pulses tick on the wrap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else if (clr)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (ena)
      begin
        if (cnt_reg == CW'(DIV - 1))
        begin
          cnt_reg <= '0;
          tick <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule // pmc_divider

// >>> tb/pmc_cpu_model.sv
// Purpose: CPU core and interrupt controller seen from the sequencer
// Assumes: pending levels come from the bench; mask is set by reset
// Notes: the mask gates every request, so a wake needs the clear pulse
`timescale 1ns/10ps
module pmc_cpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear_imask,
  input wire logic cpu_clk_en,
  input wire logic autowake_irq,
  input wire logic ext_pend,
  input wire logic halt_pend,
  input wire logic act_pend,
  output logic irq_any,
  output logic irq_halt_wake,
  output logic irq_active_wake,
  output logic imask
);
  logic imask_reg;
  // Mask: set by reset and by service, cleared by the sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      imask_reg <= 1'b1;
    else if (clear_imask)
      imask_reg <= 1'b0;
    else if (cpu_clk_en && irq_any)
      imask_reg <= 1'b1;
  end
  // Requests reach the sequencer only while unmasked
  assign imask = imask_reg;
  assign irq_any = (ext_pend | halt_pend | act_pend | autowake_irq) & ~imask_reg;
  assign irq_halt_wake = halt_pend & ~imask_reg;
  assign irq_active_wake = act_pend & ~imask_reg;
endmodule // pmc_cpu_model

// >>> tb/power_mode_controller_tb.sv
// Purpose: self-checking bench for the power mode sequencer
// Assumes: hready loops back from hreadyout; tasks return at a negedge
// Notes: stabilisation counts allow a few cycles of pipeline slack
`timescale 1ns/10ps
module power_mode_controller_tb;
  logic hclk, hresetn, hsel, hwrite, wait_instr, halt_instr, watchdog_active;
  logic ext_pend, halt_pend, act_pend;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rv;
  wire logic [31:0] hrdata;
  wire logic [2:0] mode;
  wire logic hreadyout, hresp, clear_imask, cpu_clk_en, periph_clk_en, osc_on, timer_clk_en;
  wire logic awrc_on, aw_capture_sel, autowake_irq, watchdog_reset, irq_any;
  wire logic irq_halt_wake, irq_active_wake, imask;
  int err_total, tests_run, wd_seen, c;
  localparam int STAB_SIM = 300; // Short long-delay keeps the run brief
  pmc_core #(.STAB_LONG(STAB_SIM)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .wait_instr(wait_instr), .halt_instr(halt_instr), .irq_any(irq_any),
    .irq_halt_wake(irq_halt_wake), .irq_active_wake(irq_active_wake),
    .watchdog_active(watchdog_active), .clear_imask(clear_imask),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_on(osc_on),
    .timer_clk_en(timer_clk_en), .awrc_on(awrc_on), .aw_capture_sel(aw_capture_sel),
    .autowake_irq(autowake_irq), .watchdog_reset(watchdog_reset), .mode(mode));
  pmc_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .clear_imask(clear_imask),
    .cpu_clk_en(cpu_clk_en), .autowake_irq(autowake_irq), .ext_pend(ext_pend),
    .halt_pend(halt_pend), .act_pend(act_pend), .irq_any(irq_any),
    .irq_halt_wake(irq_halt_wake), .irq_active_wake(irq_active_wake), .imask(imask));
  // 10 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Watchdog pulses are one cycle, so each is seen exactly once
  always @(posedge hclk)
    if (watchdog_reset === 1'b1)
      wd_seen++;
  task automatic complete_run;
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic near(input int n, input int e);
    chk({31'h0, n >= e - 4 && n <= e + 4}, 32'h1);
  endtask
  // Bounded wait for a mode, or for the autowake request when aw is set
  task automatic wmode(input logic [2:0] m, input logic aw, output int n);
    n = 0;
    while ((aw ? autowake_irq !== 1'b1 : mode !== m) && n < 3000)
    begin
      @(negedge hclk);
      n++;
    end
    if (n == 3000)
    begin
      err_total++;
      complete_run();
    end
  endtask
  // One bus phase: held until hready is seen high
  task automatic phase(output logic [31:0] r);
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 40)
    begin
      @(negedge hclk);
      n++;
    end
    if (n == 40)
    begin
      err_total++;
      complete_run();
    end
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
    @(posedge hclk);
  endtask
  // Single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    logic [31:0] x;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00, a};
    htrans <= 2'h2;
    hwrite <= w;
    phase(x);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    phase(r);
    @(negedge hclk);
  endtask
  // One-cycle instruction pulse, then let the mode settle
  task automatic instr(input logic h);
    @(posedge hclk);
    halt_instr <= h;
    wait_instr <= ~h;
    @(posedge hclk);
    halt_instr <= 1'b0;
    wait_instr <= 1'b0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic pulses(output int cc, output int pc);
    cc = 0;
    pc = 0;
    repeat (64)
    begin
      @(negedge hclk);
      cc += int'(cpu_clk_en === 1'b1);
      pc += int'(periph_clk_en === 1'b1);
    end
  endtask
  // Hold pending lines until the CPU model has taken the interrupt
  task automatic svc;
    int n;
    n = 0;
    while (imask !== 1'b1 && n < 100)
    begin
      @(negedge hclk);
      n++;
    end
    if (n == 100)
    begin
      err_total++;
      complete_run();
    end
    ext_pend <= 1'b0;
    halt_pend <= 1'b0;
    act_pend <= 1'b0;
  endtask
  task automatic t_regs;
    bus(0, pmc_pkg::PMC_OFS_PRESCALE, 0, rv);
    chk(rv, 32'hff);
    bus(1, pmc_pkg::PMC_OFS_PRESCALE, 0, rv);
    bus(0, pmc_pkg::PMC_OFS_PRESCALE, 0, rv);
    chk(rv, 32'hff);
    bus(1, pmc_pkg::PMC_OFS_AWCS, 32'h4, rv);
    bus(0, pmc_pkg::PMC_OFS_AWCS, 0, rv);
    chk(rv, 32'h0);
    bus(0, 8'h20, 0, rv);
    chk(rv, 32'h0);
    bus(1, pmc_pkg::PMC_OFS_PRESCALE, 32'h2, rv);
  endtask
  task automatic t_slow_wait;
    int cc, pc;
    bus(1, pmc_pkg::PMC_OFS_CLKCTRL, 32'h1, rv);
    pulses(cc, pc);
    chk(cc, 2);
    chk(pc, 2);
    instr(0);
    chk({29'h0, mode}, 32'h1);
    chk({31'h0, imask}, 32'h0);
    pulses(cc, pc);
    chk(cc, 0);
    chk(pc, 2);
    ext_pend <= 1'b1;
    wmode(3'h0, 1'b0, c);
    chk({31'h0, c < 10}, 32'h1);
    svc();
    bus(1, pmc_pkg::PMC_OFS_CLKCTRL, 0, rv);
  endtask
  task automatic t_halt;
    bus(1, pmc_pkg::PMC_OFS_CLKCTRL, 32'h6, rv);
    instr(1);
    chk({29'h0, mode}, 32'h2);
    chk({30'h0, osc_on, periph_clk_en}, 32'h0);
    chk({31'h0, imask}, 32'h0);
    ext_pend <= 1'b1;
    repeat (20) @(negedge hclk);
    chk({29'h0, mode}, 32'h2);
    halt_pend <= 1'b1;
    wmode(3'h6, 1'b0, c);
    near(c, STAB_SIM);
    wmode(3'h0, 1'b0, c);
    near(c, 16);
    svc();
    bus(1, pmc_pkg::PMC_OFS_CLKCTRL, 0, rv);
  endtask
  task automatic t_active;
    logic [31:0] tc [4] = '{32'h1, 32'h6, 32'ha, 32'h0};
    logic [31:0] ck [4] = '{32'h8, 32'h0, 32'h0, 32'h8};
    int w [4];
    watchdog_active <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      bus(1, pmc_pkg::PMC_OFS_CLKCTRL, ck[i], rv);
      bus(1, pmc_pkg::PMC_OFS_TIMCFG, tc[i], rv);
      wd_seen = 0;
      instr(1);
      chk({29'h0, mode}, i < 2 ? 32'h3 : 32'h2);
      if (i < 2)
      begin
        chk({29'h0, osc_on, timer_clk_en, periph_clk_en}, 32'h6);
        chk({31'h0, imask}, 32'h0);
        act_pend <= 1'b1;
        wmode(3'h0, 1'b0, c);
        chk({31'h0, c < 5}, 32'h1);
      end
      else
      begin
        halt_pend <= 1'b1;
        wmode(3'h0, 1'b0, c);
      end
      w[i] = wd_seen;
      svc();
    end
    chk(w[0] + w[1], 0);
    chk({31'h0, (w[2] > 0) ^ (w[3] > 0)}, 32'h1);
    watchdog_active <= 1'b0;
    bus(1, pmc_pkg::PMC_OFS_TIMCFG, 0, rv);
    bus(1, pmc_pkg::PMC_OFS_CLKCTRL, 0, rv);
  endtask
  task automatic t_autowake;
    bus(1, pmc_pkg::PMC_OFS_AWCS, 32'h1, rv);
    instr(1);
    chk({29'h0, mode}, 32'h4);
    chk({30'h0, awrc_on, osc_on}, 32'h2);
    wmode(3'h0, 1'b1, c);
    near(c + 2, 4 + 2 * 64);
    wmode(3'h0, 1'b0, c);
    near(c, 256);
    bus(0, pmc_pkg::PMC_OFS_AWCS, 0, rv);
    chk(rv, 32'h5);
    bus(0, pmc_pkg::PMC_OFS_AWCS, 0, rv);
    chk(rv, 32'h1);
    chk({31'h0, autowake_irq}, 32'h0);
    bus(1, pmc_pkg::PMC_OFS_AWCS, 32'h2, rv);
    @(negedge hclk);
    chk({31'h0, aw_capture_sel}, 32'h1);
    chk({31'h0, awrc_on}, 32'h1);
    bus(1, pmc_pkg::PMC_OFS_AWCS, 0, rv);
  endtask
  // Main sequence: reset, then each scenario from run mode
  initial
  begin
    {hresetn, hsel, hwrite, wait_instr, halt_instr, watchdog_active} = 6'h0;
    {ext_pend, halt_pend, act_pend} = 3'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (7) @(posedge hclk);
    @(negedge hclk);
    chk({29'h0, mode}, 32'h0);
    chk({31'h0, osc_on}, 32'h1);
    @(posedge hclk);
    hresetn <= 1'b1;
    // Outputs leave their reset values one edge after release
    repeat (2) @(negedge hclk);
    chk({29'h0, mode}, 32'h5);
    wmode(3'h0, 1'b0, c);
    near(c, 256);
    @(negedge hclk);
    chk({30'h0, cpu_clk_en, periph_clk_en}, 32'h3);
    t_regs();
    t_slow_wait();
    t_halt();
    t_active();
    t_autowake();
    complete_run();
  end
endmodule // power_mode_controller_tb
